// file: ddio_terminal_config.sv
// digital terminal configuration: registers over classic Wishbone, input
// sync, filter, polarity and force, and output function routing
// assumes pins are asynchronous, drive functions and encoder pulses are
// on sys_clk, and the master holds a request until ack
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ddio_terminal_config
    import ddio_pkg::*;
#(
    parameter int NUM_IN = `DDIO_NUM_IN,
    parameter int NUM_OUT = `DDIO_NUM_OUT
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_IN-1:0] inputPins,
    input wire logic [`DDIO_NUM_FUNC-1:0] driveFunctions,
    input wire logic encA,
    input wire logic encB,
    input wire logic encZ,
    output logic [NUM_OUT-1:0] outputPins,
    output logic [NUM_IN-1:0] effectiveInputs,
    output logic [NUM_IN*`DDIO_CODE_W-1:0] inputFunctionCodes
);
    localparam int TICK_CYCLES = `DDIO_TICK_CYCLES;

    // refuse sizes that the fixed register layout cannot serve
    if (NUM_IN != `DDIO_NUM_IN || NUM_OUT != `DDIO_NUM_OUT) begin : gen_bad_size
        $error("register layout serves ten inputs and six outputs only");
    end

    // byte-lane merge for writes with partial select
    function automatic logic [31:0] laneMerge(input logic [31:0] oldV,
                                              input logic [31:0] newV,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = oldV;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = newV[b*8 +: 8];
            end
        end
        return res;
    endfunction : laneMerge

    // a function code picks a drive signal; 26 and 27 are constants
    function automatic logic codeLevel(input ddio_code_type code,
                                       input logic [`DDIO_NUM_FUNC-1:0] funcs);
        logic lvl;
        lvl = 1'b0;
        if (code == `DDIO_CODE_OFF) begin
            lvl = 1'b0;
        end else if (code == `DDIO_CODE_ON) begin
            lvl = 1'b1;
        end else if (code <= `DDIO_CODE_MAX) begin
            lvl = funcs[code];
        end
        return lvl;
    endfunction : codeLevel

    logic [NUM_IN-1:0] forceMask;
    logic [NUM_IN-1:0] polarity;
    ddio_filt_type filterTime;
    ddio_route_type routeSel;
    ddio_code_type outCode [NUM_OUT];
    ddio_code_type inCode [NUM_IN];
    logic [NUM_IN-1:0] syncFirst;
    logic [NUM_IN-1:0] syncSecond;
    logic [4:0] tickCount;
    logic usTick;
    logic [31:0] next_readData;
    logic [31:0] wrValue;
    logic [5:0] wordIdx;
    logic busTake;
    logic busWrite;
    logic [5:0] outIdx;
    logic [5:0] inIdx;
    logic [NUM_OUT-1:0] next_outputs;

    ddio_filter_if #(.WIDTH(NUM_IN)) filtBus();

    // pins cross into sys_clk through two flops before anything reads them
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            syncFirst <= '0;
            syncSecond <= '0;
        end else begin
            syncFirst <= inputPins;
            syncSecond <= syncFirst;
        end
    end

    // microsecond enable for the filter counters
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tickCount <= '0;
            usTick <= 1'b0;
        end else if (tickCount == 5'(TICK_CYCLES - 1)) begin
            tickCount <= '0;
            usTick <= 1'b1;
        end else begin
            tickCount <= tickCount + 5'h01;
            usTick <= 1'b0;
        end
    end

    assign filtBus.rawLevel = syncSecond;
    assign filtBus.filterTime = filterTime;
    assign filtBus.usTick = usTick;

    ddio_input_filter #(.WIDTH(NUM_IN)) u_filter (
        .sys_clk(sys_clk),
        .reset(reset),
        .fil(filtBus.filt)
    );

    // bus decode; a register write lands on the edge that sees ack high
    assign wordIdx = wb_adr_i[7:2];
    assign busTake = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign outIdx = wordIdx - 6'(`DDIO_OFF_OUTCODE >> 2);
    assign inIdx = wordIdx - 6'(`DDIO_OFF_INCODE >> 2);

    always_comb begin
        wrValue = 32'h0000_0000;
        unique case ({wordIdx, 2'b00})
            `DDIO_OFF_FORCE: wrValue = laneMerge({22'h0, forceMask}, wb_dat_i, wb_sel_i);
            `DDIO_OFF_FILTER: wrValue = laneMerge({17'h0, filterTime}, wb_dat_i, wb_sel_i);
            `DDIO_OFF_POLARITY: wrValue = laneMerge({22'h0, polarity}, wb_dat_i, wb_sel_i);
            `DDIO_OFF_ROUTE: wrValue = laneMerge({30'h0, routeSel}, wb_dat_i, wb_sel_i);
            default: wrValue = laneMerge(32'h0000_0000, wb_dat_i, wb_sel_i);
        endcase
    end

    // single-cycle answer: ack one cycle after the request, then low again
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= busTake;
        end
    end

    // force mask and polarity words
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            forceMask <= `DDIO_RST_FORCE;
            polarity <= `DDIO_RST_POLARITY;
        end else if (busWrite) begin
            if ({wordIdx, 2'b00} == `DDIO_OFF_FORCE) begin
                forceMask <= wrValue[NUM_IN-1:0];
            end
            if ({wordIdx, 2'b00} == `DDIO_OFF_POLARITY) begin
                polarity <= wrValue[NUM_IN-1:0];
            end
        end
    end

    // filter time: zero is outside the range and is ignored
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            filterTime <= `DDIO_RST_FILTER;
        end else if (busWrite && {wordIdx, 2'b00} == `DDIO_OFF_FILTER) begin
            if (wrValue[`DDIO_FILT_W-1:0] >= `DDIO_FILT_MIN) begin
                filterTime <= wrValue[`DDIO_FILT_W-1:0];
            end
        end
    end

    // routing selector: the unused code three is refused
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            routeSel <= DDIO_ROUTE_FUNC;
        end else if (busWrite && {wordIdx, 2'b00} == `DDIO_OFF_ROUTE) begin
            if (wrValue[1:0] != 2'h3) begin
                routeSel <= ddio_route_type'(wrValue[1:0]);
            end
        end
    end

    // output function codes; values above 99 are refused
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int k = 0; k < NUM_OUT; k++) begin
                outCode[k] <= `DDIO_RST_OUTCODE_OTHER;
            end
            outCode[0] <= `DDIO_RST_OUTCODE1;
            outCode[1] <= `DDIO_RST_OUTCODE2;
        end else if (busWrite && outIdx < 6'(NUM_OUT) && wb_sel_i[0]) begin
            if (wb_dat_i[`DDIO_CODE_W-1:0] <= `DDIO_CODE_MAX) begin
                outCode[outIdx[2:0]] <= wb_dat_i[`DDIO_CODE_W-1:0];
            end
        end
    end

    // input function codes, exported to the drive's input decoder
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int k = 0; k < NUM_IN; k++) begin
                inCode[k] <= `DDIO_RST_INCODE;
            end
        end else if (busWrite && inIdx < 6'(NUM_IN) && wb_sel_i[0]) begin
            if (wb_dat_i[`DDIO_CODE_W-1:0] <= `DDIO_CODE_MAX) begin
                inCode[inIdx[3:0]] <= wb_dat_i[`DDIO_CODE_W-1:0];
            end
        end
    end

    for (genvar i = 0; i < NUM_IN; i++) begin : gen_incode
        assign inputFunctionCodes[i*`DDIO_CODE_W +: `DDIO_CODE_W] = inCode[i];
    end

    // effective input: polarity turns level into ON, force overrides
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            effectiveInputs <= '0;
        end else begin
            effectiveInputs <= ~(filtBus.filtered ^ polarity) | forceMask;
        end
    end

    // output routing; outputs three to six always follow their codes
    always_comb begin
        for (int k = 0; k < NUM_OUT; k++) begin
            next_outputs[k] = codeLevel(outCode[k], driveFunctions);
        end
        unique case (routeSel)
            DDIO_ROUTE_FUNC: begin
            end
            DDIO_ROUTE_AB: begin
                next_outputs[0] = encA;
                next_outputs[1] = encB;
            end
            DDIO_ROUTE_Z: begin
                next_outputs[0] = encZ;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            outputPins <= '0;
        end else begin
            outputPins <= next_outputs;
        end
    end

    // read mux; unmapped words read zero
    always_comb begin
        next_readData = 32'h0000_0000;
        if (outIdx < 6'(NUM_OUT)) begin
            next_readData = {25'h0, outCode[outIdx[2:0]]};
        end else if (inIdx < 6'(NUM_IN)) begin
            next_readData = {25'h0, inCode[inIdx[3:0]]};
        end else begin
            unique case ({wordIdx, 2'b00})
                `DDIO_OFF_FORCE: next_readData = {22'h0, forceMask};
                `DDIO_OFF_LEVEL: next_readData = {22'h0, filtBus.filtered};
                `DDIO_OFF_FILTER: next_readData = {17'h0, filterTime};
                `DDIO_OFF_POLARITY: next_readData = {22'h0, polarity};
                `DDIO_OFF_ROUTE: next_readData = {30'h0, routeSel};
                `DDIO_OFF_EFFECT: next_readData = {22'h0, effectiveInputs};
                `DDIO_OFF_OUTSTATE: next_readData = {26'h0, outputPins};
                default: next_readData = 32'h0000_0000;
            endcase
        end
    end

    // read data is sampled with the request, so it matches the ack cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (busTake) begin
            wb_dat_o <= next_readData;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // assertions watch design state only; the bus ones lean on a master
    // that holds its request until the edge that samples ack
    AST_FORCE_ON: assert property (forceMask[3] |=> effectiveInputs[3])
        else $error("forced input not ON");
    AST_LEVEL_READ: assert property (
        busTake && !wb_we_i && {wordIdx, 2'b00} == `DDIO_OFF_LEVEL
        |=> wb_ack_o && wb_dat_o[9:0] == $past(filtBus.filtered))
        else $error("level read mismatch");
    AST_FILTER_RANGE: assert property (
        busWrite && {wordIdx, 2'b00} == `DDIO_OFF_FILTER
        && wrValue[`DDIO_FILT_W-1:0] == 15'h0000
        |=> filterTime == $past(filterTime))
        else $error("filter time zero taken");
    AST_POLARITY_LOW: assert property (
        !forceMask[0] && !polarity[0] && !filtBus.filtered[0] |=> effectiveInputs[0])
        else $error("low-active input not ON");
    AST_ROUTE_FUNC: assert property (
        routeSel == DDIO_ROUTE_FUNC && outCode[0] == `DDIO_CODE_ON |=> outputPins[0])
        else $error("output one ignores its code");
    AST_ROUTE_REFUSE: assert property (
        busWrite && {wordIdx, 2'b00} == `DDIO_OFF_ROUTE
        && wb_sel_i[0] && wb_dat_i[1:0] == 2'h3
        |=> routeSel == $past(routeSel))
        else $error("routing code three taken");
    AST_ROUTE_AB: assert property (
        routeSel == DDIO_ROUTE_AB |=> outputPins[1:0] == {$past(encB), $past(encA)})
        else $error("encoder A/B not routed");
    AST_ROUTE_Z: assert property (
        routeSel == DDIO_ROUTE_Z && outCode[1] == `DDIO_CODE_OFF
        |=> outputPins[0] == $past(encZ) && !outputPins[1])
        else $error("Z routing wrong");
    AST_CODE_OFF: assert property (outCode[2] == `DDIO_CODE_OFF |=> !outputPins[2])
        else $error("code 26 not OFF");
    AST_CODE_REFUSE: assert property (
        busWrite && outIdx == 6'h00 && wb_sel_i[0]
        && wb_dat_i[`DDIO_CODE_W-1:0] > `DDIO_CODE_MAX
        |=> outCode[0] == $past(outCode[0]))
        else $error("output code above 99 taken");
    AST_CODE_ON: assert property (outCode[5] == `DDIO_CODE_ON |=> outputPins[5])
        else $error("code 27 not ON");
    AST_OUT_STATE: assert property (
        busTake && !wb_we_i && {wordIdx, 2'b00} == `DDIO_OFF_OUTSTATE
        |=> wb_dat_o[5:0] == $past(outputPins))
        else $error("output state read mismatch");
    AST_INCODE_RANGE: assert property (
        busWrite && inIdx == 6'h00 && wb_sel_i[0]
        && wb_dat_i[`DDIO_CODE_W-1:0] > `DDIO_CODE_MAX
        |=> inCode[0] == $past(inCode[0]))
        else $error("input code above 99 taken");
    AST_EFFECT: assert property (
        !forceMask[2] && polarity[2] |=> effectiveInputs[2] == $past(filtBus.filtered[2]))
        else $error("high-active input wrong");
    AST_ACK_ANSWER: assert property (busTake |=> wb_ack_o)
        else $error("request not answered next cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");

    // covers for the main scenarios
    COV_WRITE: cover property (busWrite && {wordIdx, 2'b00} == `DDIO_OFF_FORCE);
    COV_REFUSED: cover property (busWrite && inIdx == 6'h00
        && wb_dat_i[`DDIO_CODE_W-1:0] > `DDIO_CODE_MAX);
    COV_ROUTE_AB: cover property (routeSel == DDIO_ROUTE_AB ##1 outputPins[0]);
    COV_ROUTE_Z: cover property (routeSel == DDIO_ROUTE_Z ##1 outputPins[0]);
    COV_FILTER: cover property ($rose(filtBus.filtered[0]));
endmodule : ddio_terminal_config
`default_nettype wire

// file: ddio_terminal_cfg.svh
// constants of the digital terminal configuration block: offsets, field
// widths, reset values, function codes and timing counts
// assumes a 25 MHz system clock and word-aligned Wishbone byte addresses
// Behaviour
// - force mask bit forces its input ON
// - level register reports inputs one to ten
// - filter time 1..32767 us, default 1000
// - per-input polarity, 0 low-active, 1 high-active
// - routing 0: outputs one, two follow codes
// - routing 1: outputs carry encoder A, B
// - routing 2: output one Z, two function
// - output codes 0..99; 26 OFF, 27 ON
// - output two default 13, three default 0
// - state register reports outputs one..six bits
// - each input has function code 0..99
`ifndef DDIO_TERMINAL_CFG_SVH
`define DDIO_TERMINAL_CFG_SVH

`define DDIO_NUM_IN 10
`define DDIO_NUM_OUT 6
`define DDIO_NUM_FUNC 100
`define DDIO_CODE_W 7
`define DDIO_FILT_W 15
`define DDIO_CODE_MAX 7'h63
`define DDIO_CODE_OFF 7'h1A
`define DDIO_CODE_ON 7'h1B

`define DDIO_OFF_FORCE 8'h00
`define DDIO_OFF_LEVEL 8'h04
`define DDIO_OFF_FILTER 8'h08
`define DDIO_OFF_POLARITY 8'h0C
`define DDIO_OFF_ROUTE 8'h10
`define DDIO_OFF_EFFECT 8'h14
`define DDIO_OFF_OUTSTATE 8'h18
`define DDIO_OFF_OUTCODE 8'h20
`define DDIO_OFF_INCODE 8'h40

`define DDIO_RST_FORCE 10'h000
`define DDIO_RST_FILTER 15'h03E8
`define DDIO_RST_POLARITY 10'h000
`define DDIO_RST_ROUTE 2'h0
`define DDIO_RST_OUTCODE1 7'h09
`define DDIO_RST_OUTCODE2 7'h0D
`define DDIO_RST_OUTCODE_OTHER 7'h00
`define DDIO_RST_INCODE 7'h00
`define DDIO_FILT_MIN 15'h0001

`define DDIO_CLK_HZ 25000000
`define DDIO_TICK_US 1
`define DDIO_TICK_CYCLES ((`DDIO_CLK_HZ / 1000000) * `DDIO_TICK_US)

`endif

// file: ddio_pkg.sv
// types shared by the digital terminal configuration modules
// assumes ddio_terminal_cfg.svh supplies the widths
`default_nettype none
`include "ddio_terminal_cfg.svh"
package ddio_pkg;
    typedef enum logic [1:0] {DDIO_ROUTE_FUNC, DDIO_ROUTE_AB, DDIO_ROUTE_Z} ddio_route_type;
    typedef logic [`DDIO_CODE_W-1:0] ddio_code_type;
    typedef logic [`DDIO_FILT_W-1:0] ddio_filt_type;
endpackage : ddio_pkg
`default_nettype wire

// file: ddio_filter_if.sv
// carrier between the register logic and the input filter
// assumes both ends run on the same system clock
`timescale 1ns/10ps
`default_nettype none
interface ddio_filter_if #(parameter int WIDTH = 10);
    import ddio_pkg::*;
    logic [WIDTH-1:0] rawLevel;
    logic [WIDTH-1:0] filtered;
    ddio_filt_type filterTime;
    logic usTick;
    modport ctrl(output rawLevel, output filterTime, output usTick, input filtered);
    modport filt(input rawLevel, input filterTime, input usTick, output filtered);
endinterface : ddio_filter_if
`default_nettype wire

// file: ddio_input_filter.sv
// low-speed input filter: a level is accepted once it has held steady
// for the programmed number of microsecond ticks
// assumes synchronised inputs and a one-cycle microsecond tick
`timescale 1ns/10ps
`default_nettype none
module ddio_input_filter #(
    parameter int WIDTH = 10
) (
    input wire logic sys_clk,
    input wire logic reset,
    ddio_filter_if.filt fil
);
    import ddio_pkg::*;

    // refuse a width that leaves no terminal to filter
    if (WIDTH < 1) begin : gen_bad_width
        $error("filter width must be at least one");
    end

    // one counter per terminal; a bounce restarts its count
    for (genvar i = 0; i < WIDTH; i++) begin : gen_bit
        ddio_filt_type holdCount;
        always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                holdCount <= '0;
                fil.filtered[i] <= 1'b0;
            end else if (fil.rawLevel[i] == fil.filtered[i]) begin
                holdCount <= '0;
            end else if (fil.usTick) begin
                if (holdCount + 15'h0001 >= fil.filterTime) begin
                    fil.filtered[i] <= fil.rawLevel[i];
                    holdCount <= '0;
                end else begin
                    holdCount <= holdCount + 15'h0001;
                end
            end
        end
    end
endmodule : ddio_input_filter
`default_nettype wire

// file: ddio_field_model.sv
// field side of the digital terminals: switches and sensors that drive the
// raw input pins, with optional contact bounce after every change
// assumes the bench sets the wanted levels on sys_clk edges
`timescale 1ns/10ps
`default_nettype none
module ddio_field_model #(
    parameter int WIDTH = 10,
    parameter int BOUNCE = 12
) (
    input wire logic sys_clk,
    input wire logic [WIDTH-1:0] wantLevels,
    input wire logic bouncy,
    output logic [WIDTH-1:0] inputPins
);
    logic [WIDTH-1:0] lastWant;
    int chatter;

    initial begin
        inputPins = '0;
        lastWant = '0;
        chatter = 0;
    end

    // a mechanical contact chatters for a while before it settles, so the
    // pins show changing garbage rather than a clean step
    always @(posedge sys_clk) begin
        if (wantLevels !== lastWant) begin
            lastWant <= wantLevels;
            chatter <= bouncy ? BOUNCE : 0;
        end else if (chatter > 0) begin
            chatter <= chatter - 1;
        end
        inputPins <= (chatter > 0) ? (lastWant ^ WIDTH'($urandom)) : lastWant;
    end
endmodule : ddio_field_model
`default_nettype wire

// file: test_ddio_terminal_config.sv
// self-checking bench of the digital terminal configuration block
// assumes the field model on the pins and a classic Wishbone master here
`timescale 1ns/10ps
`default_nettype none
module test_ddio_terminal_config;
    logic sysClk, rst, wbCyc, wbStb, wbWe, wbAck, bouncy, encA, encB, encZ;
    logic [7:0] wbAdr;
    logic [3:0] wbSel, selWant;
    logic [31:0] wbDat, wbDatOut, rd;
    logic [9:0] pins, lvl, pol, frc, eff;
    logic [99:0] df;
    logic [5:0] outPins;
    logic [69:0] inCodes;
    logic [6:0] c1, c2, c3;
    logic [6:0] inExp [10];
    logic [5:0] expOut;
    logic [1:0] route;
    int failCount, totalChecks;
    logic [7:0] rstAdr [7] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24, 8'h28};
    logic [31:0] rstVal [7] = '{32'h0, 32'h3E8, 32'h0, 32'h0, 32'h9, 32'hD, 32'h0};

    ddio_terminal_config dut (.sys_clk(sysClk), .reset(rst), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDat), .wb_dat_o(wbDatOut), .wb_ack_o(wbAck), .inputPins(pins),
        .driveFunctions(df), .encA(encA), .encB(encB), .encZ(encZ),
        .outputPins(outPins), .effectiveInputs(eff), .inputFunctionCodes(inCodes));
    ddio_field_model field (.sys_clk(sysClk), .wantLevels(lvl), .bouncy(bouncy),
        .inputPins(pins));

    initial begin
        sysClk = 1'b0;
        forever #20 sysClk = ~sysClk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        totalChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check

    // one classic cycle; waits for ack, only the watchdog ends a hang;
    // read data is taken at the edge that samples ack high
    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= selWant;
        wbDat <= dat;
        do begin
            @(posedge sysClk);
        end while (wbAck !== 1'b1);
        rd = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge sysClk);
    endtask : wbXfer

    // codes 26 and 27 hold the output regardless of the drive's status bits
    function automatic logic outFor(input logic [6:0] code, input logic [99:0] f);
        if (code == 7'h1A) return 1'b0;
        if (code == 7'h1B) return 1'b1;
        return f[code];
    endfunction : outFor

    task automatic giveVerdict();
        if (failCount == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : giveVerdict

    // the run needs under two thousand cycles; a hang is cut far beyond that
    initial begin
        repeat (60000) @(posedge sysClk);
        failCount++;
        giveVerdict();
    end

    initial begin
        {rst, wbCyc, wbStb, wbWe, wbAdr, wbDat, bouncy, encA, encB, encZ} = '0;
        rst = 1'b1;
        wbSel = 4'hF;
        selWant = 4'hF;
        lvl = '0;
        df = '0;
        failCount = 0;
        totalChecks = 0;
        void'($urandom(38246));
        repeat (8) @(posedge sysClk);
        rst <= 1'b0;
        @(posedge sysClk);
        foreach (rstAdr[i]) begin
            wbXfer(1'b0, rstAdr[i], 32'h0);
            check(rd, rstVal[i], "reset value");
        end
        wbXfer(1'b1, 8'h1C, 32'hFFFFFFFF);
        wbXfer(1'b0, 8'h1C, 32'h0);
        check(rd, 32'h0, "unmapped read");
        // refused writes leave the old value in place
        wbXfer(1'b1, 8'h08, 32'h0);
        wbXfer(1'b0, 8'h08, 32'h0);
        check(rd, 32'h3E8, "filter zero taken");
        wbXfer(1'b1, 8'h08, 32'h7FFF);
        wbXfer(1'b0, 8'h08, 32'h0);
        check(rd, 32'h7FFF, "filter max");
        wbXfer(1'b1, 8'h10, 32'h3);
        wbXfer(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0, "route three taken");
        wbXfer(1'b1, 8'h20, 32'h64);
        wbXfer(1'b0, 8'h20, 32'h0);
        check(rd, 32'h9, "out code 100 taken");
        // a single byte lane leaves bits 9:8 of the force mask untouched
        selWant = 4'h1;
        wbXfer(1'b1, 8'h00, 32'h3FF);
        selWant = 4'hF;
        wbXfer(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0FF, "force lane merge");
        wbXfer(1'b1, 8'h00, 32'h0);
        // filter of 4 us: a bouncing change stays hidden well past 40 cycles
        wbXfer(1'b1, 8'h08, 32'h4);
        bouncy <= 1'b1;
        lvl <= 10'h2A5;
        repeat (40) @(posedge sysClk);
        check({22'h0, eff}, 32'h3FF, "filter too early");
        repeat (250) @(posedge sysClk);
        check({22'h0, eff}, 32'h15A, "filter level");
        wbXfer(1'b1, 8'h08, 32'h1);
        for (int i = 0; i < 8; i++) begin
            lvl <= (i == 0) ? 10'h3FF : 10'($urandom);
            pol = (i == 0) ? 10'h000 : 10'($urandom);
            frc = (i == 0) ? 10'h02A : ((i == 1) ? 10'h000 : 10'($urandom));
            bouncy <= i[0];
            wbXfer(1'b1, 8'h0C, {22'h0, pol});
            wbXfer(1'b1, 8'h00, {22'h0, frc});
            wbXfer(1'b1, 8'h04, 32'h0);
            repeat (120) @(posedge sysClk);
            wbXfer(1'b0, 8'h04, 32'h0);
            check(rd, {22'h0, lvl}, "actual levels");
            check({22'h0, eff}, {22'h0, ~(lvl ^ pol) | frc}, "effective pins");
            wbXfer(1'b0, 8'h14, 32'h0);
            check(rd, {22'h0, ~(lvl ^ pol) | frc}, "effective reg");
            wbXfer(1'b0, 8'h00, 32'h0);
            check(rd, {22'h0, frc}, "force readback");
        end
        // output six held ON by code 27; four and five keep code 0
        wbXfer(1'b1, 8'h34, 32'h1B);
        for (int j = 0; j < 9; j++) begin
            route = 2'(j % 3);
            c1 = (j == 0) ? 7'h1A : ((j == 3) ? 7'h1B : 7'($urandom_range(99, 0)));
            c2 = (j == 0) ? 7'h1B : ((j == 2) ? 7'h1A : 7'($urandom_range(99, 0)));
            c3 = (j == 1) ? 7'h1A : 7'($urandom_range(99, 0));
            df <= (j == 0) ? 100'(1) << 26 : {$urandom, $urandom, $urandom, 4'($urandom)};
            {encA, encB, encZ} <= 3'($urandom);
            wbXfer(1'b1, 8'h20, {25'h0, c1});
            wbXfer(1'b1, 8'h24, {25'h0, c2});
            wbXfer(1'b1, 8'h28, {25'h0, c3});
            wbXfer(1'b1, 8'h10, {30'h0, route});
            repeat (3) @(posedge sysClk);
            expOut[0] = (route == 2'h1) ? encA : ((route == 2'h2) ? encZ : outFor(c1, df));
            expOut[1] = (route == 2'h1) ? encB : outFor(c2, df);
            expOut[2] = outFor(c3, df);
            expOut[5:3] = {outFor(7'h1B, df), outFor(7'h00, df), outFor(7'h00, df)};
            check({26'h0, outPins}, {26'h0, expOut}, "output pins");
            wbXfer(1'b0, 8'h18, 32'h0);
            check(rd, {26'h0, expOut}, "output state reg");
            wbXfer(1'b0, 8'h10, 32'h0);
            check(rd, {30'h0, route}, "route readback");
        end
        for (int k = 0; k < 10; k++) begin
            inExp[k] = 7'($urandom_range(99, 0));
            wbXfer(1'b1, 8'(8'h40 + 4 * k), {25'h0, inExp[k]});
        end
        wbXfer(1'b1, 8'h40, 32'h64);
        repeat (2) @(posedge sysClk);
        for (int k = 0; k < 10; k++) begin
            check({25'h0, inCodes[k*7+:7]}, {25'h0, inExp[k]}, "input code");
        end
        wbXfer(1'b0, 8'h4C, 32'h0);
        check(rd, {25'h0, inExp[3]}, "input code read");
        giveVerdict();
    end
endmodule : test_ddio_terminal_config
`default_nettype wire
